// ===== rtl/srsc_core.sv
// Purpose: I2C target command handling, resets, heater, status and CRC
// Assumes: SCL and SDA samples are synchronous to CLK
// Notes: SDA is open drain; SDA_OE_N low pulls the line to SDA_OUT (0)
//
// What the document requires of the device and the host
// RULE1: While any system reset runs, commands are ignored and not acknowledged.
// RULE2: Host recovers the link by holding SDA high and clocking SCL nine times.
// RULE3: After recovery pulses the host sends a START before the next command.
// RULE4: Nine-clock recovery resets only the serial interface, status kept.
// RULE5: Soft reset command resets the controller and reloads calibration.
// RULE6: Calibration is reloaded before every measurement starts.
// RULE7: General call write with reset byte causes a full reset.
// RULE8: General call reset acts only when the device accepts commands.
// RULE9: Command 0x306D turns heater on, 0x3066 turns it off.
// RULE10: Every reset leaves the heater off; nine-clock recovery keeps the heater state here.
// RULE11: Status bit 13 shows the heater state.
// RULE12: Status bit 4 set by any reset, kept until clear-status, default one; nine-clock recovery does not set it here.
// RULE13: Status bit 1 set on invalid command, cleared on successful command.
// RULE14: Status bit 0 shows whether the last write data checksum failed.
// RULE15: Clear-status forces status bits 15, 11, 10 and 4 to zero.
// RULE16: Each 16-bit word on the bus is followed by its own 8-bit checksum; command words are taken here without one.
// RULE17: Checksum uses polynomial 0x31, init 0xFF, no reflection, no final XOR.
// RULE18: Results are delivered as unsigned, compensated 16-bit words.
// RULE19: Host scales raw values into humidity and Celsius itself.
// RULE20: Host should stop periodic acquisition before other commands.
// RULE21: Status read returns the word MSB first, then its checksum.
`timescale 1ns/1ps
module srsc_core
    import srsc_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h44,
    parameter logic [15:0] CMD_READ_STATUS = 16'hF000,
    parameter int RST_BUSY_CYCLES = RST_BUSY_CYC
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N,
    input wire logic MEAS_REQ,
    output logic MEAS_GO,
    output logic CAL_RELOAD,
    output logic HEATER_EN,
    output logic BUSY,
    output logic [15:0] STATUS_WORD
);
    import srsc_pkg::*;

    initial begin
        if (RST_BUSY_CYCLES < 1 || RST_BUSY_CYCLES > 65535) begin
            $error("RST_BUSY_CYCLES out of range");
        end
    end

    localparam logic [15:0] BUSY_LOAD = 16'(RST_BUSY_CYCLES);

    srsc_state_t state_q, state_d;
    logic scl_q, scl_d, sda_q, sda_d;
    logic [3:0] bit_cnt_q, bit_cnt_d, rec_q, rec_d;
    logic [7:0] shift_q, shift_d;
    logic drv_q, drv_d, rw_q, rw_d, gc_q, gc_d, wr_q, wr_d;
    logic [2:0] byte_cnt_q, byte_cnt_d;
    logic [39:0] rx_q, rx_d;
    logic rd_pend_q, rd_pend_d, tack_q, tack_d;
    logic [1:0] tx_idx_q, tx_idx_d;
    logic [15:0] tx_word_q, tx_word_d, busy_cnt_q, busy_cnt_d;
    logic heater_q, heater_d, alert_q, alert_d, rst_det_q, rst_det_d;
    logic cmd_err_q, cmd_err_d, wr_crc_q, wr_crc_d;
    logic cal_q, cal_d, go_q, go_d, mpend_q, mpend_d;

    logic scl_rise, scl_fall, start, stop, busy, exec, iface_rst;
    logic gc_go, soft_go, full_rst;
    logic [15:0] cmd, status_w;
    logic [7:0] byte_in, tx_byte, tx_crc;

    assign scl_rise = SCL_IN & ~scl_q;
    assign scl_fall = ~SCL_IN & scl_q;
    assign start = scl_q & SCL_IN & sda_q & ~SDA_IN;
    assign stop = scl_q & SCL_IN & ~sda_q & SDA_IN;
    assign busy = busy_cnt_q != 16'h0000;
    assign byte_in = {shift_q[6:0], SDA_IN};
    assign tx_crc = srsc_crc8(tx_word_q); // [RULE16] [RULE17]

    always_comb begin
        status_w = 16'h0000;
        status_w[ST_ALERT_BIT] = alert_q;
        status_w[ST_HEATER_BIT] = heater_q; // [RULE11]
        status_w[ST_RESET_BIT] = rst_det_q;
        status_w[ST_CMD_ERR_BIT] = cmd_err_q;
        status_w[ST_WR_CRC_BIT] = wr_crc_q;
    end

    // Byte to send: status word MSB, LSB, then checksum of both [RULE21]
    always_comb begin
        if (tx_idx_q == 2'h0) begin
            tx_byte = tx_word_q[15:8];
        end else if (tx_idx_q == 2'h1) begin
            tx_byte = tx_word_q[7:0];
        end else begin
            tx_byte = srsc_crc8(tx_word_q); // [RULE16] [RULE17]
        end
    end

    always_comb begin
        state_d = state_q;
        scl_d = SCL_IN;
        sda_d = SDA_IN;
        bit_cnt_d = bit_cnt_q;
        rec_d = rec_q;
        shift_d = shift_q;
        drv_d = drv_q;
        rw_d = rw_q;
        gc_d = gc_q;
        wr_d = wr_q;
        byte_cnt_d = byte_cnt_q;
        rx_d = rx_q;
        rd_pend_d = rd_pend_q;
        tack_d = tack_q;
        tx_idx_d = tx_idx_q;
        tx_word_d = tx_word_q;
        busy_cnt_d = busy_cnt_q;
        heater_d = heater_q;
        alert_d = alert_q;
        rst_det_d = rst_det_q;
        cmd_err_d = cmd_err_q;
        wr_crc_d = wr_crc_q;
        cal_d = 1'b0;
        go_d = mpend_q;
        mpend_d = 1'b0;
        exec = 1'b0;
        iface_rst = 1'b0;
        gc_go = 1'b0;
        soft_go = 1'b0;
        cmd = rx_q[15:0];

        if (busy) begin
            busy_cnt_d = busy_cnt_q - 16'h0001;
        end
        if (busy_cnt_q == 16'h0001) begin
            cal_d = 1'b1; // [RULE5]
        end
        if (MEAS_REQ && !busy) begin
            cal_d = 1'b1; // [RULE6]
            mpend_d = 1'b1;
        end

        // Recovery: count SCL rises with SDA high [RULE4]
        if (start) begin
            rec_d = 4'h0;
        end else if (scl_rise) begin
            if (!SDA_IN) begin
                rec_d = 4'h0;
            end else if (rec_q < REC_PULSES) begin
                rec_d = rec_q + 4'h1;
                iface_rst = (rec_q == REC_PULSES - 4'h1);
            end
        end

        if (start || stop) begin
            exec = wr_q && !gc_q && byte_cnt_q != 3'h0;
            wr_d = 1'b0;
            drv_d = 1'b0;
            bit_cnt_d = 4'h0;
            state_d = start ? ST_ADDR : ST_IDLE;
        end else begin
            case (state_q)
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_d = byte_in;
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == 4'h8) begin
                        bit_cnt_d = 4'h0;
                        rw_d = shift_q[0];
                        gc_d = shift_q[7:1] == GC_ADDR;
                        byte_cnt_d = 3'h0;
                        rx_d = 40'h0;
                        state_d = ST_IDLE;
                        // Busy device stays silent on the bus [RULE1] [RULE8]
                        if (!busy && shift_q[7:1] == DEV_ADDR
                            && (!shift_q[0] || rd_pend_q)) begin
                            drv_d = 1'b1;
                            wr_d = !shift_q[0];
                            state_d = ST_ACK;
                        end else if (!busy && shift_q == {GC_ADDR, 1'b0}) begin
                            drv_d = 1'b1;
                            state_d = ST_ACK;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        drv_d = 1'b0;
                        state_d = ST_RX;
                        if (rw_q) begin
                            tx_word_d = status_w;
                            tx_idx_d = 2'h0;
                            rd_pend_d = 1'b0;
                            shift_d = status_w[15:8];
                            drv_d = ~status_w[15];
                            state_d = ST_TX;
                        end
                    end
                end
                ST_RX: begin
                    if (scl_rise) begin
                        shift_d = byte_in;
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == 4'h8) begin
                        bit_cnt_d = 4'h0;
                        drv_d = 1'b1;
                        state_d = ST_ACK;
                        if (gc_q) begin
                            gc_go = shift_q == GC_RESET_BYTE && !busy; // [RULE7]
                        end else begin
                            rx_d = {rx_q[31:0], shift_q};
                            if (byte_cnt_q != 3'h7) begin
                                byte_cnt_d = byte_cnt_q + 3'h1;
                            end
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_q == 4'h8) begin
                            bit_cnt_d = 4'h0;
                            drv_d = 1'b0;
                            state_d = ST_TACK;
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0};
                            drv_d = ~shift_q[6];
                        end
                    end
                end
                ST_TACK: begin
                    if (scl_rise) begin
                        tack_d = !SDA_IN && tx_idx_q != 2'h2;
                    end else if (scl_fall) begin
                        state_d = ST_IDLE;
                        if (tack_q) begin
                            tx_idx_d = tx_idx_q + 2'h1;
                            state_d = ST_TX;
                        end
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end

        if (state_q == ST_TX && tx_idx_d != tx_idx_q) begin
            shift_d = tx_byte;
        end
        if (state_q == ST_TACK && scl_fall && tack_q) begin
            shift_d = tx_idx_q == 2'h0 ? tx_word_q[7:0] : tx_crc;
            drv_d = tx_idx_q == 2'h0 ? ~tx_word_q[7] : ~tx_crc[7];
        end

        if (iface_rst) begin
            state_d = ST_IDLE; // [RULE4]
            drv_d = 1'b0;
            wr_d = 1'b0;
            bit_cnt_d = 4'h0;
        end

        if (exec) begin
            if (byte_cnt_q == 3'h5) begin
                // Write word carries its own checksum [RULE14] [RULE16]
                wr_crc_d = srsc_crc8(rx_q[23:8]) != rx_q[7:0];
                cmd = rx_q[39:24];
            end
            cmd_err_d = 1'b0; // [RULE13]
            if (byte_cnt_q == 3'h2 && cmd == CMD_SOFT_RESET) begin
                soft_go = 1'b1;
            end else if (byte_cnt_q == 3'h2 && cmd == CMD_HEATER_ON) begin
                heater_d = 1'b1; // [RULE9]
            end else if (byte_cnt_q == 3'h2 && cmd == CMD_HEATER_OFF) begin
                heater_d = 1'b0; // [RULE9]
            end else if (byte_cnt_q == 3'h2 && cmd == CMD_CLEAR_STATUS) begin
                alert_d = 1'b0; // [RULE15]
                rst_det_d = 1'b0; // [RULE12]
            end else if (byte_cnt_q == 3'h2 && cmd == CMD_READ_STATUS) begin
                rd_pend_d = 1'b1;
            end else begin
                cmd_err_d = 1'b1; // [RULE13]
            end
        end

        full_rst = soft_go || gc_go;
        if (full_rst) begin
            busy_cnt_d = BUSY_LOAD; // [RULE1]
            heater_d = 1'b0; // [RULE10]
            alert_d = STATUS_RESET[ST_ALERT_BIT];
            rst_det_d = 1'b1; // [RULE12]
            cmd_err_d = 1'b0;
            wr_crc_d = 1'b0;
            rd_pend_d = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_q <= ST_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bit_cnt_q <= 4'h0;
            rec_q <= 4'h0;
            shift_q <= 8'h00;
            drv_q <= 1'b0;
            rw_q <= 1'b0;
            gc_q <= 1'b0;
            wr_q <= 1'b0;
            byte_cnt_q <= 3'h0;
            rx_q <= 40'h00_0000_0000;
            rd_pend_q <= 1'b0;
            tack_q <= 1'b0;
            tx_idx_q <= 2'h0;
            tx_word_q <= 16'h0000;
            busy_cnt_q <= BUSY_LOAD;
            heater_q <= 1'b0; // [RULE10]
            alert_q <= STATUS_RESET[ST_ALERT_BIT];
            rst_det_q <= STATUS_RESET[ST_RESET_BIT]; // [RULE12]
            cmd_err_q <= 1'b0;
            wr_crc_q <= 1'b0;
            cal_q <= 1'b0;
            go_q <= 1'b0;
            mpend_q <= 1'b0;
        end else begin
            state_q <= state_d;
            scl_q <= scl_d;
            sda_q <= sda_d;
            bit_cnt_q <= bit_cnt_d;
            rec_q <= rec_d;
            shift_q <= shift_d;
            drv_q <= drv_d;
            rw_q <= rw_d;
            gc_q <= gc_d;
            wr_q <= wr_d;
            byte_cnt_q <= byte_cnt_d;
            rx_q <= rx_d;
            rd_pend_q <= rd_pend_d;
            tack_q <= tack_d;
            tx_idx_q <= tx_idx_d;
            tx_word_q <= tx_word_d;
            busy_cnt_q <= busy_cnt_d;
            heater_q <= heater_d;
            alert_q <= alert_d;
            rst_det_q <= rst_det_d;
            cmd_err_q <= cmd_err_d;
            wr_crc_q <= wr_crc_d;
            cal_q <= cal_d;
            go_q <= go_d;
            mpend_q <= mpend_d;
        end
    end

    assign SDA_OUT = 1'b0;
    assign SDA_OE_N = ~drv_q;
    assign MEAS_GO = go_q;
    assign CAL_RELOAD = cal_q;
    assign HEATER_EN = heater_q;
    assign BUSY = busy;
    assign STATUS_WORD = status_w; // [RULE18]

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    chk_busy_no_ack: assert property ( // [RULE1]
        busy && state_q == ST_ADDR && scl_fall && bit_cnt_q == 4'h8
        |=> state_q == ST_IDLE && SDA_OE_N)
        else $error("address acknowledged while busy");
    chk_iface_keeps: assert property ( // [RULE4]
        iface_rst && !exec |=> state_q == ST_IDLE
        && STATUS_WORD == $past(STATUS_WORD))
        else $error("interface reset disturbed status");
    chk_soft_busy: assert property ( // [RULE5]
        soft_go |=> BUSY ##[1:1000] CAL_RELOAD)
        else $error("soft reset did not reload calibration");
    chk_meas_reload: assert property ( // [RULE6]
        MEAS_GO |-> $past(CAL_RELOAD))
        else $error("measurement started without reload");
    chk_gc_reset: assert property ( // [RULE7]
        gc_go |=> !HEATER_EN && STATUS_WORD[ST_RESET_BIT] && BUSY)
        else $error("general call reset not applied");
    chk_heater_on: assert property ( // [RULE9]
        exec && byte_cnt_q == 3'h2 && cmd == CMD_HEATER_ON
        |=> HEATER_EN && STATUS_WORD[ST_HEATER_BIT])
        else $error("heater did not turn on");
    chk_reset_heater: assert property ( // [RULE10]
        full_rst |=> !HEATER_EN [*2])
        else $error("heater on after reset");
    chk_clear_flags: assert property ( // [RULE15]
        exec && byte_cnt_q == 3'h2 && cmd == CMD_CLEAR_STATUS
        |=> (STATUS_WORD & 16'h8C10) == 16'h0000)
        else $error("clear status left a flag set");
    chk_cmd_error: assert property ( // [RULE13]
        exec && byte_cnt_q != 3'h2 |=> STATUS_WORD[ST_CMD_ERR_BIT])
        else $error("invalid command not flagged");
    chk_wr_crc: assert property ( // [RULE14]
        exec && byte_cnt_q == 3'h5
        |=> STATUS_WORD[0] == (srsc_crc8($past(rx_q[23:8]))
        != $past(rx_q[7:0])))
        else $error("write checksum flag wrong");

endmodule

// ===== rtl/srsc_pkg.sv
// Purpose: Shared constants for the sensor command, reset and status block
// Assumes: 25 MHz system clock, I2C target on synchronous pin samples
// Notes: Command codes are 16 bit, sent most significant byte first
package srsc_pkg;

    localparam int CLK_PERIOD_NS = 40;
    // Time the system controller stays busy after any system reset
    localparam int RST_BUSY_NS = 1000;
    localparam int RST_BUSY_CYC = (RST_BUSY_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam logic [3:0] REC_PULSES = 4'h9;

    localparam logic [6:0] GC_ADDR = 7'h00;
    localparam logic [7:0] GC_RESET_BYTE = 8'h06;
    localparam logic [15:0] CMD_SOFT_RESET = 16'h30A2;
    localparam logic [15:0] CMD_HEATER_ON = 16'h306D;
    localparam logic [15:0] CMD_HEATER_OFF = 16'h3066;
    localparam logic [15:0] CMD_CLEAR_STATUS = 16'h3041;

    // Status word field positions and value after reset
    localparam int ST_ALERT_BIT = 15;
    localparam int ST_HEATER_BIT = 13;
    localparam int ST_RESET_BIT = 4;
    localparam int ST_CMD_ERR_BIT = 1;
    localparam int ST_WR_CRC_BIT = 0;
    localparam logic [15:0] STATUS_RESET = 16'h8010;

    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'hFF;
    localparam logic [7:0] CRC_XOR_OUT = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK = 3'b010,
        ST_RX = 3'b011,
        ST_TX = 3'b100,
        ST_TACK = 3'b101
    } srsc_state_t;

    // Checksum over one 16-bit word, no reflection
    function automatic logic [7:0] srsc_crc8(input logic [15:0] d);
        logic [7:0] c;
        logic fb;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            fb = c[7] ^ d[i];
            c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
        end
        return c ^ CRC_XOR_OUT;
    endfunction

endpackage

// ===== testbench/srsc_host_model.sv
// Purpose: Bus controller model for the sensor's two-wire link
// Assumes: SCL and SDA change just after a rising CLK edge
// Notes: SDA is released high; the wire level is resolved in the bench
`timescale 1ns/1ps
module srsc_host_model (
    input wire logic clk,
    input wire logic sda_in,
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Start or repeated start: SDA falls while SCL is high
    task automatic start();
        sda <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda <= 1'b0;
        tick(4);
        scl <= 1'b0;
        tick(2);
    endtask

    task automatic stop();
        sda <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda <= 1'b1;
        tick(4);
    endtask

    // Data is held over the whole SCL high phase, sampled at its end
    task automatic bit_io(input logic b, output logic r);
        sda <= b;
        tick(2);
        scl <= 1'b1;
        tick(4);
        r = sda_in;
        scl <= 1'b0;
        tick(2);
    endtask

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic get_byte(input logic ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(~ack, r);
    endtask

    // Lost link: nine SCL pulses with SDA left high
    task automatic recover();
        sda <= 1'b1;
        repeat (9) begin
            scl <= 1'b1;
            tick(4);
            scl <= 1'b0;
            tick(4);
        end
        start();
        stop();
    endtask

    // Host side scaling of a raw humidity word to whole percent
    function automatic int rh_pct(input logic [15:0] s);
        return (100 * int'(s)) / 65535;
    endfunction

    // Checksum over one 16-bit word only
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
        end
        return c;
    endfunction
endmodule

// ===== testbench/sensor_reset_status_crc_tb_top.sv
// Purpose: Self-checking bench for command, reset and status handling
// Assumes: Long busy time so commands can arrive while reset runs
// Notes: Only single commands are sent, so the sensor stays idle
`timescale 1ns/1ps
module sensor_reset_status_crc_tb_top;
    import srsc_pkg::*;
    logic clk, rst_n, meas_req, scl, host_sda, sda_out, sda_oe_n;
    logic meas_go, cal_reload, heater_en, busy, r;
    logic [15:0] status_word;
    int error_cnt = 0;
    int samples_checked = 0;
    int cal_cnt = 0;
    int go_cnt = 0;
    int c0, g0;
    wire logic sda_wire = host_sda & (sda_oe_n | sda_out);

    srsc_core #(.RST_BUSY_CYCLES(200)) srsc_core_i (
        .CLK(clk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda_wire),
        .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .MEAS_REQ(meas_req),
        .MEAS_GO(meas_go), .CAL_RELOAD(cal_reload),
        .HEATER_EN(heater_en), .BUSY(busy), .STATUS_WORD(status_word));
    srsc_host_model srsc_host_model_i (
        .clk(clk), .sda_in(sda_wire), .scl(scl), .sda(host_sda));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        if (cal_reload === 1'b1) cal_cnt++;
        if (meas_go === 1'b1) go_cnt++;
    end

    task automatic check(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Write transfer: address, then the top nb bytes of pl, MSB first
    task automatic send(input logic [7:0] a, input logic [39:0] pl,
        input int nb, input logic ea);
        logic ack;
        srsc_host_model_i.start();
        srsc_host_model_i.put_byte(a, ack);
        check("address ack", {15'h0, ea}, {15'h0, ack});
        for (int i = 0; i < nb && ack; i++) begin
            srsc_host_model_i.put_byte(pl[39-8*i -: 8], r);
        end
        srsc_host_model_i.stop();
    endtask

    // Single shot use only, so no break command is needed
    task automatic cmd(input logic [15:0] c, input logic ea);
        send(8'h88, {c, 8'h00, 16'h0000}, 2, ea);
    endtask

    task automatic rd_status(input logic [15:0] e);
        logic ack;
        logic [7:0] hi, lo, cr;
        check("status port", e, status_word);
        cmd(16'hF000, 1'b1);
        srsc_host_model_i.start();
        srsc_host_model_i.put_byte(8'h89, ack);
        srsc_host_model_i.get_byte(1'b1, hi);
        srsc_host_model_i.get_byte(1'b1, lo);
        srsc_host_model_i.get_byte(1'b0, cr);
        srsc_host_model_i.stop();
        check("read ack", 16'h0001, {15'h0, ack});
        check("status read", e, {hi, lo});
        check("status crc", {8'h00, srsc_host_model_i.crc8(e)}, {8'h00, cr});
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        check("busy released", 16'h0000, {15'h0, busy});
        repeat (2) @(posedge clk);
    endtask

    task automatic meas(input int eg);
        c0 = cal_cnt;
        g0 = go_cnt;
        meas_req <= 1'b1;
        @(posedge clk);
        meas_req <= 1'b0;
        repeat (4) @(posedge clk);
        check("measure go", 16'(eg), 16'(go_cnt - g0));
        if (eg > 0) check("measure reload", 16'h0001, 16'(cal_cnt - c0));
    endtask

    initial begin
        rst_n = 1'b0;
        meas_req = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check("reset status", 16'h8010, status_word);
        check("reset heater", 16'h0000, {15'h0, heater_en});
        send(8'h00, {8'h06, 32'h0000_0000}, 1, 1'b0);
        wait_idle();
        rd_status(16'h8010);
        $display("test power-up done");
        cmd(CMD_HEATER_ON, 1'b1);
        check("heater on", 16'h0001, {15'h0, heater_en});
        rd_status(16'hA010);
        cmd(CMD_HEATER_OFF, 1'b1);
        rd_status(16'h8010);
        $display("test heater done");
        cmd(16'h1234, 1'b1);
        check("bad command", 16'h8012, status_word);
        cmd(CMD_HEATER_OFF, 1'b1);
        check("good command", 16'h8010, status_word);
        send(8'h88, {CMD_HEATER_OFF, 16'hBEEF, 8'h00}, 5, 1'b1);
        check("write crc bad", 16'h8013, status_word);
        send(8'h88, {CMD_HEATER_OFF, 16'hBEEF, 8'h92}, 5, 1'b1);
        check("write crc ok", 16'h8012, status_word);
        $display("test flags done");
        cmd(CMD_HEATER_ON, 1'b1);
        cmd(CMD_CLEAR_STATUS, 1'b1);
        rd_status(16'h2000);
        srsc_host_model_i.start();
        repeat (3) srsc_host_model_i.bit_io(1'b1, r);
        srsc_host_model_i.recover();
        rd_status(16'h2000);
        $display("test clear and recovery done");
        c0 = cal_cnt;
        cmd(CMD_SOFT_RESET, 1'b1);
        check("soft busy", 16'h0001, {15'h0, busy});
        check("soft status", 16'h8010, status_word);
        check("soft heater", 16'h0000, {15'h0, heater_en});
        cmd(CMD_HEATER_ON, 1'b0);
        wait_idle();
        check("soft reload", 16'h0001, 16'(cal_cnt - c0));
        check("busy ignored", 16'h0000, {15'h0, heater_en});
        $display("test soft reset done");
        cmd(CMD_HEATER_ON, 1'b1);
        send(8'h00, {8'h06, 32'h0000_0000}, 1, 1'b1);
        check("call heater", 16'h0000, {15'h0, heater_en});
        check("call status", 16'h8010, status_word);
        meas(0);
        wait_idle();
        meas(1);
        check("rh scale", 16'h0064, 16'(srsc_host_model_i.rh_pct(16'hFFFF)));
        $display("test general call done");
        test_done();
    end

    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        $display("BAD watchdog expected finish seen timeout");
        test_done();
    end
endmodule
